// *** rtl/link_control_regs.sv ***
// Link control register pair of a byte-level VPW link controller, Wishbone slave
//
// Operation
// - Ignore-frame bit set disables the receiver until a new start of frame or break symbol.
// - Hardware clears ignore-frame on start of frame or break symbol.
// - While ignoring, mask all interrupts except code 20h; hold status at reset unless code 20h arrives.
// - Ignore set mid-frame discards the rest of that frame.
// - Timing base select: 1 picks binary base, 0 picks integer base.
// - Rate field divides crystal-derived clock by 1, 2, 4 or 8.
// - Rate field takes one write after reset, then reads only.
// - Interrupt enable gates the request except for code 20h; leaving stop or wait keeps vectors.
// - Request holds until all sources cleared, or reset zeroes the vector.
// - Pending interrupts may be lost when interrupt enable is cleared.
// - Wait clock gate: 0 runs clocks in wait, 1 stops them.
// - Analog loopback resets the protocol engine; bus not driven.
// - After analog loopback, idle end-of-frame before rx, separation before tx.
// - Digital loopback routes tx output to rx input, ignoring bus edges.
// - After digital loopback, idle end-of-frame before rx, separation before tx.
// - Fast receive bit: receive-only 4X; cleared means normal speed both ways.
// - Break clears fast receive and loads the state vector with 1Ch.
// - Norm-bit format 0: CRC response bit 1, else 0; format 1 inverts.
// - In-frame response sends an active norm bit before its identifier.
`default_nettype none
module link_control_regs
   import link_ctrl_pkg::*;
#(
   parameter int EOF_CYCLES = TEOF_CYC,
   parameter int IFS_CYCLES = TIFS_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Protocol engine side
   input  wire logic        sof_i,
   input  wire logic        break_i,
   input  wire logic        frame_active_i,
   input  wire logic        bus_idle_i,
   input  wire logic        crc_resp_i,
   input  wire logic        ifr_start_i,
   input  wire logic        irq_src_i,
   input  wire logic [7:0]  state_code_i,
   input  wire logic        crystal_derived_clock_i,
   input  wire logic        cpu_wait_i,
   input  wire logic        digital_tx_out_i,
   input  wire logic        phy_rx_i,
   output logic             digital_rx_in_o,
   output logic             phy_tx_o,
   output logic             phy_tx_oe_o,
   output logic             rx_enable_o,
   output logic             rx_discard_o,
   output logic             tx_permit_o,
   output logic             engine_reset_o,
   output logic             timing_base_o,
   output logic             timing_tick_o,
   output logic             module_clk_en_o,
   output logic             fast_receive_o,
   output logic             norm_bit_o,
   output logic             norm_bit_send_o,
   output logic [7:0]       state_vector_o,
   output logic             irq_o
);
   // ****************************************
   // Synchronisers for pin-side inputs
   // ****************************************
   logic [1:0] rxs_q, xcs_q;
   logic [1:0] rxs_d, xcs_d;
   always_comb begin
      rxs_d = {rxs_q[0], phy_rx_i};
      xcs_d = {xcs_q[0], crystal_derived_clock_i};
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxs_q <= 2'h0;
         xcs_q <= 2'h0;
      end else begin
         rxs_q <= rxs_d;
         xcs_q <= xcs_d;
      end
   end

   // ****************************************
   // Register file and bus slave
   // ****************************************
   logic [7:0] prim_q, prim_d, xmit_q, xmit_d, sv_q, sv_d;
   logic       rate_locked_q, rate_locked_d;
   logic       ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic       wr, rd_sv;

   assign wr    = cyc_i && stb_i && we_i && !ack_q && sel_i[0];
   assign rd_sv = cyc_i && stb_i && !we_i && !ack_q && (adr_i == OFS_STATUS);

   always_comb begin
      prim_d        = prim_q;
      xmit_d        = xmit_q;
      rate_locked_d = rate_locked_q;
      ack_d         = cyc_i && stb_i && !ack_q;
      rdat_d        = 32'h0000_0000;
      if (wr && adr_i == OFS_PRIMARY) begin
         prim_d = dat_i[7:0] & PRIMARY_MASK;
         if (rate_locked_q) begin
            prim_d[P_RATE_H:P_RATE_L] = prim_q[P_RATE_H:P_RATE_L];
         end
         rate_locked_d = 1'b1;
      end
      if (wr && adr_i == OFS_TRANSMIT) begin
         xmit_d = dat_i[7:0] & TRANSMIT_MASK;
      end
      if (sof_i || break_i) begin
         prim_d[P_IGNORE] = 1'b0;
      end
      if (break_i) begin
         xmit_d[T_FAST] = 1'b0;
      end
      if (cyc_i && stb_i && !we_i && !ack_q) begin
         unique case (adr_i)
            OFS_PRIMARY:  rdat_d = {24'h00_0000, prim_q};
            OFS_TRANSMIT: rdat_d = {24'h00_0000, xmit_q};
            OFS_STATUS:   rdat_d = {24'h00_0000, sv_q};
            OFS_EVENTS:   rdat_d = {30'h0000_0000, rate_locked_q, irq_o};
            default:      rdat_d = 32'h0000_0000;
         endcase
      end
   end

   // State vector: holds until read or cleared by its sources
   always_comb begin
      sv_d = sv_q;
      if (prim_q[P_IGNORE]) begin
         sv_d = (state_code_i == SV_WAKE) ? SV_WAKE : SV_IDLE;
      end else if (irq_src_i) begin
         sv_d = state_code_i;
      end else if (rd_sv) begin
         sv_d = SV_IDLE;
      end
      if (break_i) begin
         sv_d = SV_BREAK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prim_q        <= PRIMARY_RESET;
         xmit_q        <= TRANSMIT_RESET;
         sv_q          <= SV_IDLE;
         rate_locked_q <= 1'b0;
         ack_q         <= 1'b0;
         rdat_q        <= 32'h0000_0000;
      end else begin
         prim_q        <= prim_d;
         xmit_q        <= xmit_d;
         sv_q          <= sv_d;
         rate_locked_q <= rate_locked_d;
         ack_q         <= ack_d;
         rdat_q        <= rdat_d;
      end
   end
   assign ack_o          = ack_q;
   assign dat_o          = rdat_q;
   assign state_vector_o = sv_q;

   // Interrupt request: wake code passes the ignore mask
   assign irq_o = (sv_q != SV_IDLE) &&
                  (prim_q[P_IRQEN] || sv_q == SV_WAKE);

   // ****************************************
   // Receiver gating
   // ****************************************
   logic in_frame_q, in_frame_d;
   always_comb begin
      in_frame_d = in_frame_q;
      if (sof_i) begin
         in_frame_d = 1'b1;
      end else if (!frame_active_i) begin
         in_frame_d = 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_frame_q <= 1'b0;
      end else begin
         in_frame_q <= in_frame_d;
      end
   end
   assign rx_discard_o = prim_q[P_IGNORE] && in_frame_q;

   // ****************************************
   // Rate divider for timing tick
   // ****************************************
   logic [2:0] div_q, div_d;
   logic       edge_x, tick_d, tick_q;
   logic       xprev_q;
   function automatic logic [2:0] rate_top(input logic [1:0] r);
      unique case (r)
         RATE_DIV1: rate_top = 3'h0;
         RATE_DIV2: rate_top = 3'h1;
         RATE_DIV4: rate_top = 3'h3;
         RATE_DIV8: rate_top = 3'h7;
      endcase
   endfunction : rate_top
   assign edge_x = xcs_q[1] && !xprev_q;
   always_comb begin
      div_d  = div_q;
      tick_d = 1'b0;
      if (edge_x && module_clk_en_o) begin
         if (div_q >= rate_top(prim_q[P_RATE_H:P_RATE_L])) begin
            div_d  = 3'h0;
            tick_d = 1'b1;
         end else begin
            div_d = div_q + 3'h1;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q   <= 3'h0;
         tick_q  <= 1'b0;
         xprev_q <= 1'b0;
      end else begin
         div_q   <= div_d;
         tick_q  <= tick_d;
         xprev_q <= xcs_q[1];
      end
   end
   assign timing_tick_o   = tick_q;
   assign timing_base_o   = prim_q[P_BASE];
   assign module_clk_en_o = !(cpu_wait_i && prim_q[P_WAIT]);

   // ****************************************
   // Loopback and post-loopback idle qualification
   // ****************************************
   logic        loop_prev_q;
   logic        req_idle_q, req_idle_d;
   logic [IDLE_W-1:0] idle_q, idle_d;
   logic        loop_any;
   logic        loop_exit;
   logic        analog_loopback_prev_q;
   assign loop_any  = xmit_q[T_ANALOG_LOOPBACK] || xmit_q[T_DIGITAL_LOOPBACK];
   // First cycle out of loopback, before the idle request is registered
   assign loop_exit = loop_prev_q && !loop_any;
   always_comb begin
      req_idle_d = req_idle_q;
      idle_d     = idle_q;
      if (loop_prev_q && !loop_any) begin
         req_idle_d = 1'b1;
         idle_d     = '0;
      end else if (req_idle_q) begin
         if (!bus_idle_i || rxs_q[1]) begin
            idle_d = '0;
         end else if (idle_q < IDLE_W'(IFS_CYCLES)) begin
            idle_d = idle_q + IDLE_W'(1);
         end else begin
            req_idle_d = 1'b0;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_prev_q <= 1'b0;
         analog_loopback_prev_q <= 1'b0;
         req_idle_q  <= 1'b0;
         idle_q      <= '0;
      end else begin
         loop_prev_q <= loop_any;
         analog_loopback_prev_q <= xmit_q[T_ANALOG_LOOPBACK];
         req_idle_q  <= req_idle_d;
         idle_q      <= idle_d;
      end
   end
   assign engine_reset_o  = xmit_q[T_ANALOG_LOOPBACK] && !analog_loopback_prev_q;
   assign rx_enable_o     = !prim_q[P_IGNORE] && !xmit_q[T_ANALOG_LOOPBACK] && !loop_exit &&
                            (!req_idle_q || idle_q >= IDLE_W'(EOF_CYCLES));
   assign tx_permit_o     = !req_idle_q && !loop_any && !loop_exit &&
                            !xmit_q[T_FAST];
   assign digital_rx_in_o = xmit_q[T_DIGITAL_LOOPBACK] ? digital_tx_out_i : rxs_q[1];
   assign phy_tx_o        = digital_tx_out_i;
   assign phy_tx_oe_o     = !loop_any && !xmit_q[T_FAST];
   assign fast_receive_o  = xmit_q[T_FAST];
   assign norm_bit_o      = crc_resp_i ^ xmit_q[T_NORM_BIT_FORMAT];
   assign norm_bit_send_o = ifr_start_i;

   // ****************************************
   // Assertions
   // ****************************************
   a_rate_write_once: assert property (@(posedge clk_i) disable iff (rst_i)
      rate_locked_q |=> $stable(prim_q[P_RATE_H:P_RATE_L]))
      else $error("rate field changed after lock");
   a_ignore_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (sof_i || break_i) |=> !prim_q[P_IGNORE])
      else $error("ignore bit not cleared by frame start");
   a_ignore_rx_off: assert property (@(posedge clk_i) disable iff (rst_i)
      prim_q[P_IGNORE] |-> !rx_enable_o)
      else $error("receiver enabled while ignoring");
   a_ignore_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      prim_q[P_IGNORE] ##1 prim_q[P_IGNORE] |-> (sv_q == SV_IDLE || sv_q == SV_WAKE))
      else $error("status moved while ignoring");
   a_break_vector: assert property (@(posedge clk_i) disable iff (rst_i)
      break_i |=> (sv_q == SV_BREAK && !xmit_q[T_FAST]))
      else $error("break did not load vector");
   a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (!prim_q[P_IRQEN] && sv_q != SV_WAKE) |-> !irq_o)
      else $error("irq while disabled");
   a_digital_loopback_route: assert property (@(posedge clk_i) disable iff (rst_i)
      xmit_q[T_DIGITAL_LOOPBACK] |-> (digital_rx_in_o == digital_tx_out_i && !phy_tx_oe_o))
      else $error("digital loopback route wrong");
   a_loop_exit_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(loop_any) |-> !tx_permit_o [*2])
      else $error("tx permitted right after loopback");
   a_analog_loopback_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(xmit_q[T_ANALOG_LOOPBACK]) |-> engine_reset_o)
      else $error("no engine reset on analog loopback");
   a_norm_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      norm_bit_o == (crc_resp_i != xmit_q[T_NORM_BIT_FORMAT]))
      else $error("norm bit polarity wrong");
   a_discard_rest: assert property (@(posedge clk_i) disable iff (rst_i)
      (prim_q[P_IGNORE] && in_frame_q) |-> rx_discard_o)
      else $error("frame not discarded while ignoring");
   a_ignore_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      prim_q[P_IGNORE] ##1 prim_q[P_IGNORE] |-> (!irq_o || sv_q == SV_WAKE))
      else $error("interrupt passed the ignore mask");
   a_rate_lock_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_i == OFS_PRIMARY) |=> rate_locked_q)
      else $error("rate field not locked by write");
   a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
      timing_tick_o |=> !timing_tick_o)
      else $error("timing tick longer than one cycle");
   a_wait_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      (cpu_wait_i && prim_q[P_WAIT]) |-> !module_clk_en_o)
      else $error("clocks run in wait with gate set");
   a_wait_run: assert property (@(posedge clk_i) disable iff (rst_i)
      !prim_q[P_WAIT] |-> module_clk_en_o)
      else $error("clocks stopped with gate clear");
   a_vector_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (sv_q != SV_IDLE && !rd_sv && !irq_src_i && !prim_q[P_IGNORE]) |=> (sv_q != SV_IDLE))
      else $error("state vector dropped without a read");
   a_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_sv && !irq_src_i && !break_i && !prim_q[P_IGNORE]) |=> (sv_q == SV_IDLE))
      else $error("state vector not cleared by read");
   a_irq_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (sv_q != SV_IDLE && prim_q[P_IRQEN]) |-> irq_o)
      else $error("request dropped while a source is pending");
   a_analog_loopback_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      xmit_q[T_ANALOG_LOOPBACK] |-> !phy_tx_oe_o)
      else $error("bus driven in analog loopback");
   a_exit_rx_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_idle_q && idle_q < IDLE_W'(EOF_CYCLES)) |-> !rx_enable_o)
      else $error("receive enabled before end-of-frame idle");
   a_exit_tx_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      req_idle_q |-> !tx_permit_o)
      else $error("transmit permitted before separation idle");
   a_fast_rx_only: assert property (@(posedge clk_i) disable iff (rst_i)
      xmit_q[T_FAST] |-> (!tx_permit_o && !phy_tx_oe_o))
      else $error("transmit allowed in fast receive");
   a_norm_send: assert property (@(posedge clk_i) disable iff (rst_i)
      ifr_start_i |-> norm_bit_send_o)
      else $error("no norm bit at response start");
   c_break: cover property (@(posedge clk_i) disable iff (rst_i) break_i ##1 irq_o);
   c_loop_exit: cover property (@(posedge clk_i) disable iff (rst_i) $fell(req_idle_q));
   c_rate_lock: cover property (@(posedge clk_i) disable iff (rst_i) $rose(rate_locked_q));
   c_wake_ignored: cover property (@(posedge clk_i) disable iff (rst_i)
      prim_q[P_IGNORE] && irq_o);
   c_digital_loopback_echo: cover property (@(posedge clk_i) disable iff (rst_i)
      xmit_q[T_DIGITAL_LOOPBACK] && digital_rx_in_o);
endmodule : link_control_regs
`default_nettype wire

// *** rtl/link_ctrl_pkg.sv ***
// Package: offsets, field positions and constants of the link control register pair
`default_nettype none
package link_ctrl_pkg;
   // ****************************************
   // Register map (word offsets in bytes)
   // ****************************************
   localparam logic [3:0] OFS_PRIMARY  = 4'h0;
   localparam logic [3:0] OFS_TRANSMIT = 4'h4;
   localparam logic [3:0] OFS_STATUS   = 4'h8;
   localparam logic [3:0] OFS_EVENTS   = 4'hC;
   // ****************************************
   // Primary control fields
   // ****************************************
   localparam int P_IGNORE = 7;
   localparam int P_BASE   = 6;
   localparam int P_RATE_H = 5;
   localparam int P_RATE_L = 4;
   localparam int P_IRQEN  = 1;
   localparam int P_WAIT   = 0;
   localparam logic [7:0] PRIMARY_MASK  = 8'hF3;
   localparam logic [7:0] PRIMARY_RESET = 8'h00;
   // ****************************************
   // Transmit control fields
   // ****************************************
   localparam int T_ANALOG_LOOPBACK = 7;
   localparam int T_DIGITAL_LOOPBACK = 6;
   localparam int T_FAST  = 5;
   localparam int T_NORM_BIT_FORMAT  = 4;
   localparam logic [7:0] TRANSMIT_MASK  = 8'hF0;
   localparam logic [7:0] TRANSMIT_RESET = 8'h00;
   // ****************************************
   // State vector codes
   // ****************************************
   localparam logic [7:0] SV_IDLE   = 8'h00;
   localparam logic [7:0] SV_WAKE   = 8'h20;
   localparam logic [7:0] SV_BREAK  = 8'h1C;
   // ****************************************
   // Timing (module clock 40 MHz)
   // ****************************************
   localparam int CLK_HZ      = 40_000_000;
   localparam int TEOF_US     = 280;
   localparam int TIFS_US     = 300;
   localparam int TEOF_CYC    = (TEOF_US * (CLK_HZ / 1_000_000));
   localparam int TIFS_CYC    = (TIFS_US * (CLK_HZ / 1_000_000));
   localparam int IDLE_W      = 16;
   localparam logic [1:0] RATE_DIV1 = 2'h0;
   localparam logic [1:0] RATE_DIV2 = 2'h1;
   localparam logic [1:0] RATE_DIV4 = 2'h2;
   localparam logic [1:0] RATE_DIV8 = 2'h3;
endpackage : link_ctrl_pkg
`default_nettype wire

// *** verif/link_control_regs_test.sv ***
// Self-checking bench for the link control register pair
`default_nettype none
module link_control_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   import link_ctrl_pkg::*;
   // ****************************************
   // Harness
   // ****************************************
   localparam int EOF_N = 8;
   localparam int IFS_N = 10;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [3:0]  adr_i = 4'h0, sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, r;
   logic        sof_i = 0, break_i = 0, frame_active_i = 0, bus_idle_i = 0;
   logic        crc_resp_i = 0, ifr_start_i = 0, irq_src_i = 0, cpu_wait_i = 0;
   logic        digital_tx_out_i = 0, xcvr_loop = 0, node_drive = 0, rst_seen = 0;
   logic [7:0]  state_code_i = 8'h00, state_vector_o;
   logic [2:0]  xdiv = 3'h0;
   logic        ack_o, phy_rx_i, digital_rx_in_o, phy_tx_o, phy_tx_oe_o, rx_enable_o;
   logic        rx_discard_o, tx_permit_o, engine_reset_o, timing_base_o, timing_tick_o;
   logic        module_clk_en_o, fast_receive_o, norm_bit_o, norm_bit_send_o, irq_o;
   int          n_mismatch = 0, comparisons = 0, cycles = 0, n, n_ifr = 0;
   wire logic   crystal_derived_clock_i = xdiv[2];

   link_control_regs #(.EOF_CYCLES(EOF_N), .IFS_CYCLES(IFS_N)) dut (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .sof_i, .break_i, .frame_active_i, .bus_idle_i, .crc_resp_i, .ifr_start_i,
      .irq_src_i, .state_code_i, .crystal_derived_clock_i, .cpu_wait_i,
      .digital_tx_out_i, .phy_rx_i, .digital_rx_in_o, .phy_tx_o, .phy_tx_oe_o,
      .rx_enable_o, .rx_discard_o, .tx_permit_o, .engine_reset_o, .timing_base_o,
      .timing_tick_o, .module_clk_en_o, .fast_receive_o, .norm_bit_o,
      .norm_bit_send_o, .state_vector_o, .irq_o);
   phy_model xcvr (.tx_i(phy_tx_o), .oe_i(phy_tx_oe_o), .loop_i(xcvr_loop),
      .node_i(node_drive), .rx_o(phy_rx_i));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Crystal-derived clock is one eighth of the bus clock
   always @(posedge clk_i) begin
      xdiv <= xdiv + 3'h1;
      cycles <= cycles + 1;
      if (engine_reset_o === 1'b1) rst_seen <= 1'b1;
      if (norm_bit_send_o === 1'b1) n_ifr <= n_ifr + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic settle(input int k);
      repeat (k) @(posedge clk_i);
   endtask : settle

   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask : wb

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(r, {24'h0, e});
   endtask : rd

   // Event pulse: 0 start of frame, 1 break, 2 vector source, 3 response start
   task automatic ev(input int k, input logic [7:0] c);
      @(posedge clk_i);
      {sof_i, break_i, irq_src_i, ifr_start_i} <= 4'h8 >> k;
      state_code_i <= c;
      @(posedge clk_i);
      {sof_i, break_i, irq_src_i, ifr_start_i} <= 4'h0;
      settle(3);
   endtask : ev

   task automatic reset_dut();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : reset_dut

   // Loopback just cleared: receive after idle end-of-frame, transmit after separation
   task automatic recover();
      int rn;
      int tn;
      rn = 0;
      tn = 0;
      bus_idle_i <= 1'b0;
      settle(20);
      chk({rx_enable_o, tx_permit_o}, 2'h0);
      @(posedge clk_i);
      bus_idle_i <= 1'b1;
      for (int i = 1; i < 30; i++) begin
         @(posedge clk_i);
         if (rx_enable_o === 1'b1 && rn == 0) rn = i;
         if (tx_permit_o === 1'b1 && tn == 0) tn = i;
      end
      chk(rn >= EOF_N && rn <= EOF_N + 3, 1'h1);
      chk(tn >= IFS_N && tn <= IFS_N + 3, 1'h1);
   endtask : recover

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      reset_dut();
      settle(1);
      rd(OFS_PRIMARY, 8'h00);
      rd(OFS_TRANSMIT, 8'h00);
      rd(4'h2, 8'h00);
      chk({phy_tx_oe_o, rx_enable_o, rst_seen}, 3'h6);
      $display("test done: reset values");
      for (int k = 0; k < 4; k++) begin
         reset_dut();
         wb(1'b1, OFS_PRIMARY, 8'(k << 4));
         n = 0;
         repeat (256) begin
            @(posedge clk_i);
            if (timing_tick_o === 1'b1) n++;
         end
         chk(n >= (32 >> k) - 1 && n <= (32 >> k) + 1, 1'h1);
      end
      $display("test done: rate divide");
      wb(1'b1, OFS_PRIMARY, 8'hCF);
      rd(OFS_PRIMARY, 8'hF3);
      cpu_wait_i <= 1'b1;
      settle(1);
      chk({timing_base_o, module_clk_en_o}, 2'h2);
      wb(1'b1, OFS_PRIMARY, 8'h00);
      rd(OFS_PRIMARY, 8'h30);
      settle(1);
      chk({timing_base_o, module_clk_en_o}, 2'h1);
      cpu_wait_i <= 1'b0;
      $display("test done: primary fields");
      frame_active_i <= 1'b1;
      ev(0, 8'h00);
      wb(1'b1, OFS_PRIMARY, 8'h82);
      settle(1);
      chk({rx_enable_o, rx_discard_o}, 2'h1);
      ev(2, 8'h04);
      chk(irq_o, 1'h0);
      rd(OFS_STATUS, 8'h00);
      ev(2, SV_WAKE);
      chk(irq_o, 1'h1);
      rd(OFS_STATUS, SV_WAKE);
      ev(0, 8'h00);
      frame_active_i <= 1'b0;
      rd(OFS_PRIMARY, 8'h32);
      chk(rx_enable_o, 1'h1);
      ev(2, 8'h04);
      settle(8);
      chk(irq_o, 1'h1);
      rd(OFS_STATUS, 8'h04);
      settle(2);
      chk(irq_o, 1'h0);
      wb(1'b1, OFS_PRIMARY, 8'h00);
      ev(2, 8'h04);
      chk(irq_o, 1'h0);
      rd(OFS_STATUS, 8'h04);
      $display("test done: ignore and interrupts");
      xcvr_loop <= 1'b1;
      wb(1'b1, OFS_TRANSMIT, 8'h80);
      settle(1);
      chk({phy_tx_oe_o, rst_seen}, 2'h1);
      rd(OFS_TRANSMIT, 8'h80);
      xcvr_loop <= 1'b0;
      wb(1'b1, OFS_TRANSMIT, 8'h00);
      recover();
      $display("test done: analog loopback");
      node_drive <= 1'b1;
      wb(1'b1, OFS_TRANSMIT, 8'h40);
      settle(1);
      chk({digital_rx_in_o, phy_tx_oe_o, phy_tx_o}, 3'h0);
      digital_tx_out_i <= 1'b1;
      node_drive <= 1'b0;
      settle(1);
      chk({digital_rx_in_o, phy_tx_oe_o, phy_tx_o}, 3'h5);
      digital_tx_out_i <= 1'b0;
      wb(1'b1, OFS_TRANSMIT, 8'h00);
      recover();
      $display("test done: digital loopback");
      wb(1'b1, OFS_TRANSMIT, 8'h20);
      settle(1);
      chk({fast_receive_o, phy_tx_oe_o}, 2'h2);
      wb(1'b1, OFS_PRIMARY, 8'h80);
      ev(1, 8'h00);
      chk(state_vector_o, SV_BREAK);
      rd(OFS_TRANSMIT, 8'h00);
      rd(OFS_STATUS, SV_BREAK);
      rd(OFS_PRIMARY, 8'h30);
      $display("test done: fast receive and break");
      for (int i = 0; i < 4; i++) begin
         crc_resp_i <= i[0];
         wb(1'b1, OFS_TRANSMIT, {3'h0, i[1], 4'h0});
         ev(3, 8'h00);
         chk(norm_bit_o, i[0] ^ i[1]);
      end
      chk(n_ifr, 32'h4);
      $display("test done: norm bit format");
      report_and_stop();
   end
endmodule : link_control_regs_test
`default_nettype wire

// *** verif/phy_model.sv ***
// Transceiver and bus model at the far side of the link pins
`default_nettype none
module phy_model (
   input  wire logic tx_i,
   input  wire logic oe_i,
   input  wire logic loop_i,
   input  wire logic node_i,
   output logic      rx_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Passive bus is pulled low; another node may drive it high
   assign rx_o = loop_i ? tx_i : ((oe_i & tx_i) | node_i);
endmodule : phy_model
`default_nettype wire
